//--- lstc_defs.svh
`ifndef LSTC_DEFS_SVH
`define LSTC_DEFS_SVH

// ****************************************
// Widths
// ****************************************
`define LSTC_TRIM_W          8
`define LSTC_CNT_W           8
`define LSTC_EDGE_W          3

// ****************************************
// Measurement and correction figures
// ****************************************
`define LSTC_EDGE_FIRST      3'h1
`define LSTC_EDGE_LAST       3'h5
`define LSTC_MAX_STEP        8'h04
`define LSTC_TIMER_PRESCALE  32
`define LSTC_TRIM_MAX        9'h0ff

// ****************************************
// Reset values
// ****************************************
`define LSTC_TRIM_RESET      8'h80
`define LSTC_NOMINAL_RESET   8'hd0

// ****************************************
// Timing
// ****************************************
`define LSTC_CLK_PERIOD_NS   5
`define LSTC_APPLY_PERIOD_MS 10
`define LSTC_APPLY_CYCLES    ((`LSTC_APPLY_PERIOD_MS * 1000000) / `LSTC_CLK_PERIOD_NS)
`define LSTC_COMP_LIMIT_NS   7400
`define LSTC_COMP_CYCLES     (`LSTC_COMP_LIMIT_NS / `LSTC_CLK_PERIOD_NS)

`endif

//--- lstc_pkg.sv
// ****************************************
// Shared types
// ****************************************
package lstc_pkg;

    // Static configuration, held stable by the integrator
    typedef struct packed {
        logic [7:0] trim_init;           // Factory trim loaded at init
        logic [7:0] max_total_corr;      // Largest cumulative correction
        logic [7:0] min_correction_step; // Smaller changes are dropped
        logic [7:0] nominal_count;       // Expected count at nominal clock
        logic [7:0] corr_factor;         // Integer steps per count
    } lstc_cfg_t;

    // Controller states
    typedef enum logic [2:0] {
        LSTC_INIT  = 3'b000,
        LSTC_IDLE  = 3'b001,
        LSTC_ARMED = 3'b010,
        LSTC_MEAS  = 3'b011,
        LSTC_COMP  = 3'b100,
        LSTC_READY = 3'b101
    } lstc_state_t;

endpackage : lstc_pkg

//--- lstc_sync2.sv
`timescale 1ns/1ps

// ****************************************
// Two-stage level synchroniser
// ****************************************
module lstc_sync2 (
    // Clock and control
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic clk_en,
    // Async level in, synchronised level out
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_q;  // First stage, read only by second stage
    logic meta_d;
    logic sync_q;  // Second stage
    logic sync_d;

    // Next values; idle LIN line is recessive high
    always_comb begin
        meta_d = meta_q;
        sync_d = sync_q;
        if (clk_en) begin
            meta_d = async_in;
            sync_d = meta_q;
        end
    end

    // Registers
    always_ff @(posedge clock) begin
        if (rst) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule : lstc_sync2

//--- lstc_tick.sv
`timescale 1ns/1ps

// ****************************************
// Periodic tick generator
// ****************************************
module lstc_tick #(
    parameter int unsigned PERIOD = 2000000  // Cycles between ticks
) (
    // Clock and control
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic clk_en,
    // One-cycle tick
    output logic      tick
);
    localparam int unsigned CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;

    logic [CW-1:0] cnt_q;   // Cycles since last tick
    logic [CW-1:0] cnt_d;
    logic          tick_q;  // Registered tick pulse
    logic          tick_d;

    // Next values; wraps at PERIOD-1
    always_comb begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (clk_en) begin
            if (cnt_q == CW'(PERIOD - 1)) begin
                cnt_d  = '0;
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + CW'(1);
            end
        end else begin
            tick_d = tick_q;  // Frozen with the rest
        end
    end

    // Registers
    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

endmodule : lstc_tick

//--- lstc_trim_ctrl.sv
// Notes on behaviour
// - Break report arms synch field timing
// - Stop at fifth falling edge, then compute
// - Apply at synch end only with flag
// - Apply flag set by 10 ms tick
// - Correction ready well before field end
// - Each trim change below two percent
// - Init derives trim limits; saturate updates
// - Truncating arithmetic underestimates the deviation
// - Field counted with an 8-bit counter
// - One trim step assumed 0.4 percent
// - Clock within 14, then 1.5 percent
// - Measure first to fifth falling edge
// - Count above nominal moves trim upward
// - Changes below minimum step are discarded
`timescale 1ns/1ps
`include "lstc_defs.svh"

// ****************************************
// LIN synch field trim controller
// ****************************************
module lstc_trim_ctrl #(
    parameter int unsigned APPLY_CYCLES = `LSTC_APPLY_CYCLES,   // Apply tick period in cycles
    parameter int unsigned PRESCALE     = `LSTC_TIMER_PRESCALE  // Clocks per timer count
) (
    // Clock and control
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              clk_en,
    // LIN receive pin and receiver events
    input  wire logic              lin_rx,
    input  wire logic              break_det,
    input  wire logic              synch_done,
    // Static configuration
    input  wire lstc_pkg::lstc_cfg_t cfg,
    // Trim and status
    output logic [7:0]             trim_value,
    output logic [7:0]             trim_upper_limit,
    output logic [7:0]             trim_lower_limit,
    output logic [7:0]             meas_count,
    output logic [7:0]             correction_mag,
    output logic                   correction_sign,
    output logic                   periodic_apply_flag,
    output logic                   trim_updated
);
    import lstc_pkg::*;

    localparam int unsigned PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;

    // ****************************************
    // Pin synchronisation and edge detect
    // ****************************************
    logic rx_s;       // Synchronised receive line
    logic rx_prev_q;  // Previous synchronised level
    logic rx_prev_d;  // Next previous level
    logic fall;       // Recessive to dominant edge

    lstc_sync2 u_rx_sync (
        .clock    (clock),
        .rst      (rst),
        .clk_en   (clk_en),
        .async_in (lin_rx),
        .sync_out (rx_s)
    );

    // Next previous level; frozen with the rest while disabled
    always_comb begin
        rx_prev_d = rx_prev_q;
        if (clk_en) begin
            rx_prev_d = rx_s;
        end
    end

    // Edge detection only looks at the second stage
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_prev_q <= 1'b1;
        end else begin
            rx_prev_q <= rx_prev_d;
        end
    end

    assign fall = rx_prev_q & ~rx_s;

    // ****************************************
    // Periodic apply tick
    // ****************************************
    logic tick;  // One-cycle pulse each apply period

    lstc_tick #(
        .PERIOD (APPLY_CYCLES)
    ) u_tick (
        .clock  (clock),
        .rst    (rst),
        .clk_en (clk_en),
        .tick   (tick)
    );

    // ****************************************
    // Controller state
    // ****************************************
    lstc_state_t     state_q, state_d;     // Controller state
    logic [PW-1:0]   pre_q, pre_d;         // Timer prescaler
    logic [7:0]      cnt_q, cnt_d;         // Synch field count
    logic [2:0]      edge_q, edge_d;       // Falling edges seen
    logic [7:0]      trim_q, trim_d;       // Oscillator trim
    logic [7:0]      upper_q, upper_d;     // Trim ceiling
    logic [7:0]      lower_q, lower_d;     // Trim floor
    logic [7:0]      mag_q, mag_d;         // Correction magnitude
    logic            sign_q, sign_d;       // High means move upward
    logic            flag_q, flag_d;       // Periodic apply flag
    logic            upd_q, upd_d;         // Trim write pulse

    // Combinational helpers
    logic [7:0]      diff;                 // Distance from nominal
    logic [15:0]     prod;                 // Steps before capping
    logic [8:0]      sum;                  // Upward candidate
    logic [7:0]      room_dn;              // Steps left to floor
    logic [8:0]      lim_hi;               // Unclipped ceiling

    // Next values for the whole controller
    always_comb begin
        state_d = state_q;
        pre_d   = pre_q;
        cnt_d   = cnt_q;
        edge_d  = edge_q;
        trim_d  = trim_q;
        upper_d = upper_q;
        lower_d = lower_q;
        mag_d   = mag_q;
        sign_d  = sign_q;
        flag_d  = flag_q;
        upd_d   = 1'b0;
        // Deviation: count over nominal means a fast clock
        diff    = (cnt_q > cfg.nominal_count) ? (cnt_q - cfg.nominal_count)
                                              : (cfg.nominal_count - cnt_q);
        // Integer factor truncates, so the step is never too large
        prod    = 16'(diff) * 16'(cfg.corr_factor);
        sum     = {1'b0, trim_q} + {1'b0, mag_q};
        room_dn = trim_q - lower_q;
        lim_hi  = {1'b0, cfg.trim_init} + {1'b0, cfg.max_total_corr};
        if (!clk_en) begin
            upd_d = upd_q;  // Everything frozen
        end else begin
            // Tick sets the flag; consuming it below never loses a tick
            if (tick) begin
                flag_d = 1'b1;
            end
            unique case (state_q)
                // Load factory trim and derive the limits
                LSTC_INIT: begin
                    trim_d  = cfg.trim_init;
                    // Budget bounds how far the trimmed clock can drift from factory
                    upper_d = (lim_hi > `LSTC_TRIM_MAX) ? 8'hff : lim_hi[7:0];
                    lower_d = (cfg.trim_init > cfg.max_total_corr) ?
                              (cfg.trim_init - cfg.max_total_corr) : 8'h00;
                    state_d = LSTC_IDLE;
                end
                // Nothing in flight
                LSTC_IDLE: begin
                end
                // Timing begins at the first falling edge
                LSTC_ARMED: begin
                    if (fall) begin
                        pre_d   = '0;
                        cnt_d   = 8'h00;
                        edge_d  = `LSTC_EDGE_FIRST;
                        state_d = LSTC_MEAS;
                    end
                end
                // Count prescaled clocks until the fifth edge
                LSTC_MEAS: begin
                    if (pre_q == PW'(PRESCALE - 1)) begin
                        pre_d = '0;
                        cnt_d = cnt_q + 8'h01;
                    end else begin
                        pre_d = pre_q + PW'(1);
                    end
                    if (fall) begin
                        edge_d = edge_q + 3'h1;
                        if (edge_q == `LSTC_EDGE_LAST - 3'h1) begin
                            state_d = LSTC_COMP;
                        end
                    end
                    // Synch byte ended early: field was malformed
                    if (synch_done) begin
                        state_d = LSTC_IDLE;
                    end
                end
                // One cycle of arithmetic, far inside the budget
                LSTC_COMP: begin
                    sign_d  = cnt_q > cfg.nominal_count;
                    mag_d   = (prod > 16'(`LSTC_MAX_STEP)) ? `LSTC_MAX_STEP
                                                           : prod[7:0];
                    state_d = LSTC_READY;
                end
                // Apply when the synch character is complete
                LSTC_READY: begin
                    if (synch_done) begin
                        state_d = LSTC_IDLE;
                        if (flag_q) begin
                            flag_d = tick;  // Set wins over clear
                            if (mag_q >= cfg.min_correction_step
                                && mag_q != 8'h00) begin
                                if (sign_q) begin
                                    trim_d = (sum > {1'b0, upper_q}) ? upper_q
                                                                     : sum[7:0];
                                end else begin
                                    trim_d = (mag_q > room_dn) ? lower_q
                                                               : (trim_q - mag_q);
                                end
                                upd_d = 1'b1;
                            end
                        end
                    end
                end
                default: begin
                    state_d = LSTC_IDLE;
                end
            endcase
            // A new break restarts the measurement from any state but init
            if (break_det && state_q != LSTC_INIT) begin
                state_d = LSTC_ARMED;
            end
        end
    end

    // Registers
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= LSTC_INIT;
            pre_q   <= '0;
            cnt_q   <= 8'h00;
            edge_q  <= 3'h0;
            trim_q  <= `LSTC_TRIM_RESET;
            upper_q <= 8'hff;
            lower_q <= 8'h00;
            mag_q   <= 8'h00;
            sign_q  <= 1'b0;
            flag_q  <= 1'b0;
            upd_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            pre_q   <= pre_d;
            cnt_q   <= cnt_d;
            edge_q  <= edge_d;
            trim_q  <= trim_d;
            upper_q <= upper_d;
            lower_q <= lower_d;
            mag_q   <= mag_d;
            sign_q  <= sign_d;
            flag_q  <= flag_d;
            upd_q   <= upd_d;
        end
    end

    // ****************************************
    // Outputs, all straight from flip-flops
    // ****************************************
    assign trim_value          = trim_q;
    assign trim_upper_limit    = upper_q;
    assign trim_lower_limit    = lower_q;
    assign meas_count          = cnt_q;
    assign correction_mag      = mag_q;
    assign correction_sign     = sign_q;
    assign periodic_apply_flag = flag_q;
    assign trim_updated        = upd_q;

    // ****************************************
    // Checks
    // ****************************************
    AST_ARM: assert property (@(posedge clock) disable iff (rst || !clk_en)
        (break_det && state_q != LSTC_INIT) |=> state_q == LSTC_ARMED)
        else $error("break did not arm measurement");

    AST_STOP: assert property (@(posedge clock) disable iff (rst || !clk_en)
        (state_q == LSTC_MEAS && fall && edge_q == 3'h4 && !break_det && !synch_done)
        |=> state_q == LSTC_COMP ##1 (state_q == LSTC_READY || $past(break_det)))
        else $error("fifth edge did not stop measurement");

    AST_NOAPPLY: assert property (@(posedge clock) disable iff (rst || !clk_en)
        (state_q == LSTC_READY && synch_done && !flag_q) |=> ($stable(trim_q) && !upd_q))
        else $error("trim changed without apply flag");

    AST_TICK: assert property (@(posedge clock) disable iff (rst || !clk_en)
        tick |=> flag_q)
        else $error("tick did not set apply flag");

    AST_STEP: assert property (@(posedge clock) disable iff (rst || !clk_en)
        (state_q != LSTC_INIT && $past(state_q) != LSTC_INIT && trim_q > $past(trim_q))
        |-> (trim_q - $past(trim_q)) <= `LSTC_MAX_STEP)
        else $error("trim rose by more than the step cap");

    AST_STEP_DN: assert property (@(posedge clock) disable iff (rst || !clk_en)
        (state_q != LSTC_INIT && $past(state_q) != LSTC_INIT && trim_q < $past(trim_q))
        |-> ($past(trim_q) - trim_q) <= `LSTC_MAX_STEP)
        else $error("trim fell by more than the step cap");

    AST_RANGE: assert property (@(posedge clock) disable iff (rst || !clk_en)
        (state_q != LSTC_INIT) |-> (trim_q <= upper_q && trim_q >= lower_q))
        else $error("trim outside saturation range");

    AST_UNDER: assert property (@(posedge clock) disable iff (rst || !clk_en)
        (state_q == LSTC_COMP && cfg.corr_factor <= 8'h01) |=> (mag_q <= diff || state_q != LSTC_READY))
        else $error("correction exceeds measured deviation");

    AST_SIGN: assert property (@(posedge clock) disable iff (rst || !clk_en)
        (state_q == LSTC_READY) |-> (sign_q == (cnt_q > cfg.nominal_count)))
        else $error("correction sign disagrees with count");

    AST_MIN: assert property (@(posedge clock) disable iff (rst || !clk_en)
        upd_q |-> (mag_q >= cfg.min_correction_step && mag_q != 8'h00))
        else $error("sub-minimum correction applied");

endmodule : lstc_trim_ctrl

//--- lstc_lin_master.sv
`timescale 1ns/1ps

// ****************************************
// LIN master: break field, then synch byte
// ****************************************
module lstc_lin_master #(
    parameter int unsigned BIT_CYCLES = 101,  // Clocks per bit
    parameter int unsigned BREAK_BITS = 13    // Dominant bits in the break
) (
    // Clock and frame request
    input  wire logic clock,
    input  wire logic start,
    // Line and receiver events
    output logic      lin_rx,
    output logic      break_det,
    output logic      synch_done
);
    // Start bit, 0x55 lsb first, stop bit
    localparam logic [9:0] SYNCH_BITS = 10'h2aa;

    // Idle line is pulled up, so it rests high
    initial begin
        lin_rx     = 1'b1;
        break_det  = 1'b0;
        synch_done = 1'b0;
    end

    // One frame per request; the break's own fall comes before arming
    always begin
        @(posedge clock iff start);
        @(negedge clock);
        lin_rx = 1'b0;
        repeat (BREAK_BITS * BIT_CYCLES) @(negedge clock);
        lin_rx = 1'b1;
        repeat (BIT_CYCLES) @(negedge clock);
        break_det = 1'b1;
        @(negedge clock);
        break_det = 1'b0;
        repeat (BIT_CYCLES) @(negedge clock);
        // Five falls, first to fifth spans eight bits
        for (int i = 0; i < 10; i++) begin
            lin_rx = SYNCH_BITS[i];
            repeat (BIT_CYCLES) @(negedge clock);
        end
        synch_done = 1'b1;
        @(negedge clock);
        synch_done = 1'b0;
    end
endmodule : lstc_lin_master

//--- lstc_trim_ctrl_tb.sv
`timescale 1ns/1ps
`include "lstc_defs.svh"

// ****************************************
// Trim controller testbench
// ****************************************
module lstc_trim_ctrl_tb;
    import lstc_pkg::*;

    localparam int BIT   = 101;          // Clocks per LIN bit
    localparam int PRE   = 5;            // Keeps 8*BIT/PRE off a boundary
    localparam int APPLY = 5500;         // Longer than two frames
    localparam int CNT   = 8 * BIT / PRE; // Expected captured count
    localparam int LIMIT = 90000;        // Run ceiling in cycles

    logic       clock = 1'b0;
    logic       rst   = 1'b1;
    logic       clk_en = 1'b1;
    logic       start = 1'b0;
    logic       lin_rx, break_det, synch_done;
    lstc_cfg_t  cfg;
    logic [7:0] trim_value, trim_upper_limit, trim_lower_limit, meas_count, correction_mag;
    logic       correction_sign, periodic_apply_flag, trim_updated;
    int         num_errors = 0;
    int         n_checks   = 0;
    int         cyc        = 0;
    int         rel_cyc    = 0;
    int         exp_trim, up_lim, lo_lim;

    // ****************************************
    // Design, partner, clock, watchdog
    // ****************************************
    lstc_trim_ctrl #(.APPLY_CYCLES(APPLY), .PRESCALE(PRE)) dut_u (
        .clock(clock), .rst(rst), .clk_en(clk_en), .lin_rx(lin_rx), .break_det(break_det),
        .synch_done(synch_done), .cfg(cfg), .trim_value(trim_value),
        .trim_upper_limit(trim_upper_limit), .trim_lower_limit(trim_lower_limit),
        .meas_count(meas_count), .correction_mag(correction_mag),
        .correction_sign(correction_sign), .periodic_apply_flag(periodic_apply_flag),
        .trim_updated(trim_updated));

    lstc_lin_master #(.BIT_CYCLES(BIT)) master_u (
        .clock(clock), .start(start), .lin_rx(lin_rx), .break_det(break_det),
        .synch_done(synch_done));

    initial begin
        forever #2.5 clock = ~clock;
    end

    // Hang guard: a stuck wait ends as a failure
    always @(posedge clock) begin
        cyc++;
        if (cyc > LIMIT) begin
            num_errors++;
            wrap_up();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    // Reset with a given factory trim and correction budget
    task automatic do_reset(input int init, input int maxc);
        @(negedge clock);
        rst = 1'b1;
        cfg.trim_init      = init[7:0];
        cfg.max_total_corr = maxc[7:0];
        repeat (5) @(negedge clock);
        check("trim_reset", trim_value, `LSTC_TRIM_RESET);
        rst = 1'b0;
        rel_cyc = cyc;
        repeat (3) @(negedge clock);
        up_lim = (init + maxc > 255) ? 255 : init + maxc;
        lo_lim = (init < maxc) ? 0 : init - maxc;
        check("upper_limit", trim_upper_limit, up_lim);
        check("lower_limit", trim_lower_limit, lo_lim);
        check("trim_init", trim_value, init);
        exp_trim = init;
    endtask : do_reset

    // Bounded wait for the apply flag
    task automatic wait_flag();
        int k;
        k = 0;
        while (periodic_apply_flag !== 1'b1 && k < APPLY + 100) begin
            @(negedge clock);
            k++;
        end
        check("flag_wait", periodic_apply_flag, 1'b1);
    endtask : wait_flag

    // One frame against a chosen nominal count; apply says whether the flag is up
    task automatic frame(input int nominal, input bit apply);
        int  mag, nt;
        bit  sgn, elig;
        cfg.nominal_count = nominal[7:0];
        if (apply) wait_flag();
        start = 1'b1;
        @(negedge clock);
        start = 1'b0;
        // Wake on the falling edge that raises synch_done, before the edge that takes it
        @(posedge synch_done);
        sgn = CNT > nominal;
        mag = (sgn ? CNT - nominal : nominal - CNT) * cfg.corr_factor;
        if (mag > `LSTC_MAX_STEP) mag = `LSTC_MAX_STEP;
        check("meas_count", meas_count, CNT);
        check("correction_mag", correction_mag, mag);
        check("correction_sign", correction_sign, sgn);
        check("flag_at_synch", periodic_apply_flag, apply);
        elig = apply && mag >= cfg.min_correction_step && mag != 0;
        nt = exp_trim;
        if (elig) nt = sgn ? ((nt + mag > up_lim) ? up_lim : nt + mag)
                           : ((nt - mag < lo_lim) ? lo_lim : nt - mag);
        @(negedge clock);
        // An eligible write pulses even when clamped to the old value
        check("trim_updated", trim_updated, elig);
        check("trim_value", trim_value, nt);
        check("flag_after", periodic_apply_flag, 1'b0);
        @(negedge clock);
        check("updated_end", trim_updated, 1'b0);
        exp_trim = nt;
    endtask : frame

    // ****************************************
    // Scenarios
    // ****************************************
    // Limits after init; a 20-cycle enable gap must push the first tick back
    task automatic sc_limits_and_tick();
        do_reset(8'h80, 8'h06);
        clk_en = 1'b0;
        repeat (20) @(negedge clock);
        check("frozen_flag", periodic_apply_flag, 1'b0);
        clk_en = 1'b1;
        wait_flag();
        check("tick_period", (cyc - rel_cyc >= APPLY + 18) && (cyc - rel_cyc <= APPLY + 23), 1'b1);
    endtask : sc_limits_and_tick

    // Small upward step, count above nominal
    task automatic sc_apply_up();
        frame(159, 1'b1);
    endtask : sc_apply_up

    // Capped step, then a back-to-back frame with the flag already spent
    task automatic sc_cap_then_refuse();
        frame(150, 1'b1);
        frame(170, 1'b0);
    endtask : sc_cap_then_refuse

    // Already at the upper limit
    task automatic sc_saturate_up();
        frame(150, 1'b1);
    endtask : sc_saturate_up

    // Downward step, then a change below the minimum step
    task automatic sc_down_then_small();
        frame(170, 1'b1);
        frame(160, 1'b1);
    endtask : sc_down_then_small

    // Trim near both ends of the range must not wrap
    task automatic sc_no_wrap();
        do_reset(8'hfd, 8'h10);
        frame(150, 1'b1);
        do_reset(8'h03, 8'h10);
        frame(170, 1'b1);
    endtask : sc_no_wrap

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        cfg = '{trim_init: 8'h80, max_total_corr: 8'h06, min_correction_step: 8'h02,
                nominal_count: 8'ha1, corr_factor: 8'h01};
        sc_limits_and_tick();
        sc_apply_up();
        sc_cap_then_refuse();
        sc_saturate_up();
        sc_down_then_small();
        sc_no_wrap();
        wrap_up();
    end
endmodule : lstc_trim_ctrl_tb
